// *** design/fls_pkg.sv ***
// constants shared by the flow limit switch and parameter menu block
// assumes a single 250 MHz clock and an active-low asynchronous reset
//
// Contract
// - position-1 steps go limit A, char A, hyst A, B trio, then code.
// - filter, units, range and endpoints appear only after code 111.
// - a filter setting is held for display and analog settling.
// - output range is either zero-based or live-zero current.
// - two flow endpoints are stored for the low and high output ends.
// - position 2 on a shown parameter enters edit with flashing cursor.
// - in edit, position 2 bumps the digit, position 1 moves cursor.
// - moving the cursor past the last digit commits the edit.
// - thirty idle seconds discard the edit and show the measured value.
// - minimum switch alarms when flow falls below its limit.
// - minimum switch clears only above limit plus hysteresis.
// - maximum switch alarms when flow rises above its limit.
// - maximum switch clears only below limit minus hysteresis.
// - alarm lights the red indicator and shows an alarm message.
// - switch outputs are high when normal and low in alarm.
// - an overloaded output is switched off and the overload shown.
package fls_pkg;

  // ----------------------------------------------------------------
  // menu items, also the register index of each stored parameter
  // ----------------------------------------------------------------
  localparam logic [3:0] IT_LIM_A = 4'h0;
  localparam logic [3:0] IT_CHAR_A = 4'h1;
  localparam logic [3:0] IT_HYS_A = 4'h2;
  localparam logic [3:0] IT_LIM_B = 4'h3;
  localparam logic [3:0] IT_CHAR_B = 4'h4;
  localparam logic [3:0] IT_HYS_B = 4'h5;
  localparam logic [3:0] IT_CODE = 4'h6;
  localparam logic [3:0] IT_FILTER = 4'h7;
  localparam logic [3:0] IT_UNITS = 4'h8;
  localparam logic [3:0] IT_RANGE = 4'h9;
  localparam logic [3:0] IT_SPAN_LO = 4'ha;
  localparam logic [3:0] IT_SPAN_HI = 4'hb;
  localparam int NUM_PARAMS = 12;
  localparam int ITEMS_PER_SWITCH = 3;

  // ----------------------------------------------------------------
  // register port map beyond the parameter words
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_STATUS = 4'hc;
  localparam logic [3:0] REG_FLOW = 4'hd;
  localparam int ST_ALARM_POS = 0;
  localparam int ST_OVLD_POS = 2;
  localparam int ST_UNLOCK_POS = 4;
  localparam int ST_EDIT_POS = 5;
  localparam int ST_ITEM_POS = 8;

  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [15:0] UNLOCK_CODE = 16'h0111;
  localparam logic [15:0] CHAR_MIN = 16'h0000;
  localparam logic [15:0] RANGE_ZERO = 16'h0000;
  localparam logic [NUM_PARAMS*16-1:0] PARAM_RST = {
    16'h0100, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000,
    16'h0010, 16'h0000, 16'h0050, 16'h0010, 16'h0000, 16'h0050};
  localparam logic [1:0] MSG_NONE = 2'h0;
  localparam logic [1:0] MSG_MENU = 2'h1;
  localparam logic [1:0] MSG_ALARM = 2'h2;
  localparam logic [1:0] MSG_OVERLOAD = 2'h3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMEOUT_S = 30;
  localparam int TIMEOUT_TICKS = TIMEOUT_S * (1000000000 / TICK_NS);
  localparam int BLINK_MS = 250;
  localparam int BLINK_TICKS = BLINK_MS * (1000000 / TICK_NS);

  typedef enum logic [1:0] {
    MENU_NORMAL,
    MENU_BROWSE,
    MENU_EDIT
  } fls_menu_t;

endpackage : fls_pkg

// *** design/fls_param_mem.sv ***
// parameter store: one 16-bit word per menu item
// assumes one writer per cycle; read data are registered
`timescale 1ns/1ps
module fls_param_mem (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic we_in,
  input wire logic [3:0] waddr_in,
  input wire logic [15:0] wdata_in,
  input wire logic [3:0] raddr_in,
  output logic [15:0] rdata_out,
  output logic [fls_pkg::NUM_PARAMS*16-1:0] words_out
);

  genvar g;
  generate
    for (g = 0; g < fls_pkg::NUM_PARAMS; g++) begin : g_word
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          words_out[g*16 +: 16] <= fls_pkg::PARAM_RST[g*16 +: 16];
        end else if (we_in && waddr_in == 4'(g)) begin
          words_out[g*16 +: 16] <= wdata_in;
        end
      end
    end
  endgenerate

  wire logic raddr_ok = raddr_in < 4'(fls_pkg::NUM_PARAMS);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 16'h0000;
    end else begin
      rdata_out <= raddr_ok ? words_out[raddr_in*16 +: 16] : 16'h0000;
    end
  end

endmodule : fls_param_mem

// *** design/fls_limit.sv ***
// one limit switch with hysteresis, judged on each flow sample
// limit and hysteresis arrive as four bcd digits, flow as binary
`timescale 1ns/1ps
module fls_limit (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sample_in,
  input wire logic [15:0] flow_in,
  input wire logic [15:0] limit_bcd_in,
  input wire logic [15:0] hyst_bcd_in,
  input wire logic mode_max_in,
  output logic alarm_out
);

  function automatic logic [17:0] bcd2bin(input logic [15:0] b);
    bcd2bin = 18'(b[15:12]) * 18'd1000 + 18'(b[11:8]) * 18'd100 +
              18'(b[7:4]) * 18'd10 + 18'(b[3:0]);
  endfunction : bcd2bin

  wire logic [17:0] lim = bcd2bin(limit_bcd_in);
  wire logic [17:0] hys = bcd2bin(hyst_bcd_in);
  wire logic [17:0] flow = {2'b00, flow_in};
  wire logic [17:0] upper = lim + hys;
  // below zero the maximum switch can never release; that is intended
  wire logic lower_ok = lim >= hys;
  wire logic [17:0] lower = lim - hys;

  wire logic min_set = !mode_max_in && flow < lim;
  wire logic min_clr = !mode_max_in && flow > upper;
  wire logic max_set = mode_max_in && flow > lim;
  wire logic max_clr = mode_max_in && lower_ok && flow < lower;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      alarm_out <= 1'b0;
    end else if (sample_in) begin
      if (min_set || max_set) begin
        alarm_out <= 1'b1;
      end else if (min_clr || max_clr) begin
        alarm_out <= 1'b0;
      end
    end
  end

  min_set_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    sample_in && !mode_max_in && flow < lim |=> alarm_out)
    else $error("minimum switch missed alarm");
  min_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    alarm_out && !mode_max_in && flow <= upper |=> alarm_out)
    else $error("minimum switch released inside hysteresis");
  max_set_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    sample_in && mode_max_in && flow > lim |=> alarm_out)
    else $error("maximum switch missed alarm");
  max_clear_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    sample_in && mode_max_in && flow < lower && lower_ok && flow <= lim
    |=> !alarm_out)
    else $error("maximum switch did not release");

endmodule : fls_limit

// *** design/fls_top.sv ***
// limit switches and ring-operated parameter menu of a flow sensor
// ring positions and overload sense are pins; flow samples and the
// register port come from logic on the same clock
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
module fls_top #(
  parameter int unsigned TICK_CYC = fls_pkg::TICK_CYC,
  parameter int unsigned TIMEOUT_TICKS = fls_pkg::TIMEOUT_TICKS
) (
  input wire logic MCLK_IN,
  input wire logic RESET_N_IN,
  input wire logic RING_POS1_IN,
  input wire logic RING_POS2_IN,
  input wire logic [1:0] OVLD_IN,
  input wire logic [15:0] FLOW_IN,
  input wire logic FLOW_VALID_IN,
  input wire logic [3:0] REG_ADDR_IN,
  input wire logic [15:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [15:0] REG_RDATA_OUT,
  output logic [1:0] SW_LEVEL_OUT,
  output logic [1:0] SW_OE_OUT,
  output logic LED_RED_OUT,
  output logic [1:0] DISP_MSG_OUT,
  output logic [3:0] DISP_ITEM_OUT,
  output logic [15:0] DISP_VALUE_OUT,
  output logic DISP_EDIT_OUT,
  output logic [1:0] DISP_CURSOR_OUT,
  output logic DISP_CURSOR_ON_OUT,
  output logic [15:0] FILTER_OUT,
  output logic [15:0] UNITS_OUT,
  output logic LIVE_ZERO_OUT,
  output logic [15:0] SPAN_LO_OUT,
  output logic [15:0] SPAN_HI_OUT
);

  // ----------------------------------------------------------------
  // pin synchronisers and ring edges
  // ----------------------------------------------------------------
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [1:0] ring_prev_r;

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      ring_prev_r <= 2'h0;
    end else begin
      sync1_r <= {OVLD_IN, RING_POS2_IN, RING_POS1_IN};
      sync2_r <= sync1_r;
      ring_prev_r <= sync2_r[1:0];
    end
  end

  // a turn counts once, on its arrival at the position
  wire logic step_p1 = sync2_r[0] && !ring_prev_r[0];
  wire logic step_p2 = sync2_r[1] && !ring_prev_r[1];
  wire logic [1:0] ovld = sync2_r[3:2];

  // ----------------------------------------------------------------
  // millisecond tick, idle timeout and cursor blink
  // ----------------------------------------------------------------
  logic [17:0] tick_cnt_r;
  logic [14:0] idle_cnt_r;
  logic [7:0] blink_cnt_r;
  logic cursor_on_r;
  fls_pkg::fls_menu_t menu_r;

  wire logic tick = tick_cnt_r == 18'(TICK_CYC - 1);
  wire logic in_menu = menu_r != fls_pkg::MENU_NORMAL;
  wire logic timeout = in_menu && tick &&
                       idle_cnt_r == 15'(TIMEOUT_TICKS - 1);
  wire logic blink = tick && blink_cnt_r == 8'(fls_pkg::BLINK_TICKS - 1);

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      tick_cnt_r <= 18'h00000;
      idle_cnt_r <= 15'h0000;
      blink_cnt_r <= 8'h00;
    end else begin
      tick_cnt_r <= tick ? 18'h00000 : tick_cnt_r + 18'h00001;
      if (!in_menu || step_p1 || step_p2 || timeout) begin
        idle_cnt_r <= 15'h0000;
      end else if (tick) begin
        idle_cnt_r <= idle_cnt_r + 15'h0001;
      end
      if (tick) begin
        blink_cnt_r <= blink ? 8'h00 : blink_cnt_r + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // parameter store
  // ----------------------------------------------------------------
  logic [3:0] item_r;
  logic [15:0] edit_buf_r;
  logic [1:0] cursor_r;
  logic unlocked_r;
  logic [15:0] cur_word;
  logic [fls_pkg::NUM_PARAMS*16-1:0] words;

  wire logic choice_item = item_r == fls_pkg::IT_CHAR_A ||
                           item_r == fls_pkg::IT_CHAR_B ||
                           item_r == fls_pkg::IT_RANGE;
  wire logic last_digit = choice_item || cursor_r == 2'd3;
  wire logic commit = menu_r == fls_pkg::MENU_EDIT && step_p1 && last_digit;
  wire logic bus_wr = REG_WR_IN &&
                      REG_ADDR_IN < 4'(fls_pkg::NUM_PARAMS);
  // a bus write in the commit cycle wins; the ring edit is then lost
  wire logic mem_we = bus_wr || commit;
  wire logic [3:0] mem_waddr = bus_wr ? REG_ADDR_IN : item_r;
  wire logic [15:0] mem_wdata = bus_wr ? REG_WDATA_IN : edit_buf_r;

  fls_param_mem u_mem (
    .clk_in(MCLK_IN),
    .rst_n_in(RESET_N_IN),
    .we_in(mem_we),
    .waddr_in(mem_waddr),
    .wdata_in(mem_wdata),
    .raddr_in(item_r),
    .rdata_out(cur_word),
    .words_out(words)
  );

  // ----------------------------------------------------------------
  // digit editing: the cursor runs from the most significant digit
  // ----------------------------------------------------------------
  wire logic [1:0] dig_sel = 2'd3 - cursor_r;
  logic [15:0] bumped;

  genvar d;
  generate
    for (d = 0; d < 4; d++) begin : g_digit
      wire logic [3:0] dv = edit_buf_r[d*4 +: 4];
      // nine wraps to zero and never carries into the next digit
      assign bumped[d*4 +: 4] = (dig_sel != 2'(d)) ? dv :
                                (dv >= 4'h9) ? 4'h0 : dv + 4'h1;
    end
  endgenerate

  wire logic [15:0] edit_nxt = choice_item ?
                               {15'h0000, ~edit_buf_r[0]} : bumped;
  wire logic [3:0] last_item = unlocked_r ? fls_pkg::IT_SPAN_HI :
                                            fls_pkg::IT_CODE;
  wire logic code_ok = item_r == fls_pkg::IT_CODE &&
                       edit_buf_r == fls_pkg::UNLOCK_CODE;

  // ----------------------------------------------------------------
  // menu state machine
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      menu_r <= fls_pkg::MENU_NORMAL;
      item_r <= fls_pkg::IT_LIM_A;
      edit_buf_r <= 16'h0000;
      cursor_r <= 2'd0;
      unlocked_r <= 1'b0;
      cursor_on_r <= 1'b0;
    end else if (timeout) begin
      menu_r <= fls_pkg::MENU_NORMAL;
      unlocked_r <= 1'b0;
      cursor_on_r <= 1'b0;
    end else begin
      case (menu_r)
        fls_pkg::MENU_NORMAL: begin
          if (step_p1) begin
            menu_r <= fls_pkg::MENU_BROWSE;
            item_r <= fls_pkg::IT_LIM_A;
          end
        end
        fls_pkg::MENU_BROWSE: begin
          if (step_p2) begin
            menu_r <= fls_pkg::MENU_EDIT;
            edit_buf_r <= cur_word;
            cursor_r <= 2'd0;
            cursor_on_r <= 1'b1;
          end else if (step_p1 && item_r == last_item) begin
            menu_r <= fls_pkg::MENU_NORMAL;
            unlocked_r <= 1'b0;
          end else if (step_p1) begin
            item_r <= item_r + 4'h1;
          end
        end
        fls_pkg::MENU_EDIT: begin
          if (blink) begin
            cursor_on_r <= !cursor_on_r;
          end
          if (commit) begin
            menu_r <= fls_pkg::MENU_BROWSE;
            cursor_on_r <= 1'b0;
            if (code_ok) begin
              unlocked_r <= 1'b1;
            end
          end else if (step_p1) begin
            cursor_r <= cursor_r + 2'd1;
          end else if (step_p2) begin
            edit_buf_r <= edit_nxt;
          end
        end
        default: begin
          menu_r <= fls_pkg::MENU_NORMAL;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // limit switches and their pins
  // ----------------------------------------------------------------
  logic [1:0] alarm;
  logic [1:0] ovld_r;

  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_switch
      localparam int BASE = s * fls_pkg::ITEMS_PER_SWITCH;
      fls_limit u_limit_switch (
        .clk_in(MCLK_IN),
        .rst_n_in(RESET_N_IN),
        .sample_in(FLOW_VALID_IN),
        .flow_in(FLOW_IN),
        .limit_bcd_in(words[(BASE + fls_pkg::IT_LIM_A)*16 +: 16]),
        .hyst_bcd_in(words[(BASE + fls_pkg::IT_HYS_A)*16 +: 16]),
        .mode_max_in(words[(BASE + fls_pkg::IT_CHAR_A)*16 +: 16] !=
                     fls_pkg::CHAR_MIN),
        .alarm_out(alarm[s])
      );
      always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
          SW_LEVEL_OUT[s] <= 1'b0;
          SW_OE_OUT[s] <= 1'b0;
          ovld_r[s] <= 1'b0;
        end else begin
          SW_LEVEL_OUT[s] <= !alarm[s];
          SW_OE_OUT[s] <= !ovld[s];
          ovld_r[s] <= ovld[s];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // display, configuration outputs and register read
  // ----------------------------------------------------------------
  wire logic [1:0] msg_nxt = (|ovld_r) ? fls_pkg::MSG_OVERLOAD :
                             (|alarm) ? fls_pkg::MSG_ALARM :
                             in_menu ? fls_pkg::MSG_MENU : fls_pkg::MSG_NONE;
  wire logic [15:0] status = {4'h0, item_r, 2'b00,
                              menu_r == fls_pkg::MENU_EDIT, unlocked_r,
                              ovld_r, alarm};
  wire logic [15:0] rd_nxt =
    (REG_ADDR_IN < 4'(fls_pkg::NUM_PARAMS)) ? words[REG_ADDR_IN*16 +: 16] :
    (REG_ADDR_IN == fls_pkg::REG_STATUS) ? status :
    (REG_ADDR_IN == fls_pkg::REG_FLOW) ? FLOW_IN : 16'h0000;

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      REG_RDATA_OUT <= 16'h0000;
      LED_RED_OUT <= 1'b0;
      DISP_MSG_OUT <= fls_pkg::MSG_NONE;
      DISP_ITEM_OUT <= 4'h0;
      DISP_VALUE_OUT <= 16'h0000;
      DISP_EDIT_OUT <= 1'b0;
      DISP_CURSOR_OUT <= 2'd0;
      DISP_CURSOR_ON_OUT <= 1'b0;
      FILTER_OUT <= 16'h0000;
      UNITS_OUT <= 16'h0000;
      LIVE_ZERO_OUT <= 1'b0;
      SPAN_LO_OUT <= 16'h0000;
      SPAN_HI_OUT <= 16'h0000;
    end else begin
      REG_RDATA_OUT <= REG_RD_IN ? rd_nxt : 16'h0000;
      LED_RED_OUT <= |alarm;
      DISP_MSG_OUT <= msg_nxt;
      DISP_ITEM_OUT <= item_r;
      DISP_VALUE_OUT <= (menu_r == fls_pkg::MENU_EDIT) ? edit_buf_r :
                        (menu_r == fls_pkg::MENU_BROWSE) ? cur_word : FLOW_IN;
      DISP_EDIT_OUT <= menu_r == fls_pkg::MENU_EDIT;
      DISP_CURSOR_OUT <= cursor_r;
      DISP_CURSOR_ON_OUT <= cursor_on_r;
      FILTER_OUT <= words[fls_pkg::IT_FILTER*16 +: 16];
      UNITS_OUT <= words[fls_pkg::IT_UNITS*16 +: 16];
      LIVE_ZERO_OUT <= words[fls_pkg::IT_RANGE*16 +: 16] !=
                       fls_pkg::RANGE_ZERO;
      SPAN_LO_OUT <= words[fls_pkg::IT_SPAN_LO*16 +: 16];
      SPAN_HI_OUT <= words[fls_pkg::IT_SPAN_HI*16 +: 16];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  step_order_a: assert property (@(posedge MCLK_IN)
    disable iff (!RESET_N_IN)
    menu_r == fls_pkg::MENU_BROWSE && step_p1 && !step_p2 && !timeout &&
    item_r < fls_pkg::IT_CODE |=> item_r == $past(item_r) + 4'h1)
    else $error("menu did not step to the next item");
  lock_wrap_a: assert property (@(posedge MCLK_IN)
    disable iff (!RESET_N_IN)
    menu_r == fls_pkg::MENU_BROWSE && !unlocked_r && step_p1 && !step_p2 &&
    item_r == fls_pkg::IT_CODE |=> menu_r == fls_pkg::MENU_NORMAL)
    else $error("locked menu went past the code item");
  edit_enter_a: assert property (@(posedge MCLK_IN)
    disable iff (!RESET_N_IN)
    menu_r == fls_pkg::MENU_BROWSE && step_p2 && !timeout
    |=> menu_r == fls_pkg::MENU_EDIT && cursor_r == 2'd0 ##1
        DISP_CURSOR_ON_OUT && DISP_EDIT_OUT)
    else $error("edit mode not entered with cursor");
  commit_a: assert property (@(posedge MCLK_IN)
    disable iff (!RESET_N_IN)
    commit && !bus_wr && !timeout
    |=> item_r == $past(item_r) ##1 cur_word == $past(edit_buf_r, 2))
    else $error("edit was not committed");
  timeout_a: assert property (@(posedge MCLK_IN)
    disable iff (!RESET_N_IN)
    timeout |=> menu_r == fls_pkg::MENU_NORMAL && !unlocked_r)
    else $error("idle timeout ignored");
  digit_wrap_a: assert property (@(posedge MCLK_IN)
    disable iff (!RESET_N_IN)
    menu_r == fls_pkg::MENU_EDIT && step_p2 && !step_p1 && !timeout &&
    !choice_item && cursor_r == 2'd2 && edit_buf_r[7:4] == 4'h9
    |=> edit_buf_r == {$past(edit_buf_r[15:8]), 4'h0,
                       $past(edit_buf_r[3:0])})
    else $error("digit wrap disturbed its neighbour");
  alarm_pin_a: assert property (@(posedge MCLK_IN)
    disable iff (!RESET_N_IN)
    $rose(alarm[0]) |=> !SW_LEVEL_OUT[0] && LED_RED_OUT ##1
                        DISP_MSG_OUT != fls_pkg::MSG_NONE)
    else $error("alarm not shown on pin, lamp and display");
  overload_off_a: assert property (@(posedge MCLK_IN)
    disable iff (!RESET_N_IN)
    ovld[1] |=> !SW_OE_OUT[1] ##1 DISP_MSG_OUT == fls_pkg::MSG_OVERLOAD)
    else $error("overloaded output not switched off");

endmodule : fls_top

// *** tb/fls_ring_model.sv ***
// operator turning the programming ring, plus the switch line receiver
// assumes the bench calls press and reads rx_level_out
`timescale 1ns/1ps
module fls_ring_model (
  input wire logic clk_in,
  input wire logic [1:0] sw_level_in,
  input wire logic [1:0] sw_oe_in,
  output logic pos1_out,
  output logic pos2_out,
  output logic [1:0] rx_level_out
);
  // an undriven line is pulled down, so a dead output reads as alarm
  assign rx_level_out = sw_level_in & sw_oe_in;
  initial begin
    pos1_out = 1'b0;
    pos2_out = 1'b0;
  end
  // held long enough to pass the pin synchronisers
  task press(input logic two);
    @(posedge clk_in);
    if (two) pos2_out <= 1'b1;
    else pos1_out <= 1'b1;
    repeat (6) @(posedge clk_in);
    pos1_out <= 1'b0;
    pos2_out <= 1'b0;
    repeat (6) @(posedge clk_in);
  endtask : press
endmodule : fls_ring_model

// *** tb/fls_top_tb_top.sv ***
// self-checking bench for the limit switches and ring menu
// assumes short tick and timeout parameters; no alarm at reset
`timescale 1ns/1ps
module fls_top_tb_top;
  logic clk, rst_n, fv, wr, rd, led, edit, con, lz, p1, p2;
  logic [1:0] ovld, lvl, oe, msg, cur, rx;
  logic [3:0] addr, item;
  logic [15:0] flow, wdata, rdata, val, filt, units, slo, shi, d;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  fls_top #(.TICK_CYC(4), .TIMEOUT_TICKS(8)) fls_top_inst (
    .MCLK_IN(clk), .RESET_N_IN(rst_n), .RING_POS1_IN(p1),
    .RING_POS2_IN(p2), .OVLD_IN(ovld), .FLOW_IN(flow),
    .FLOW_VALID_IN(fv), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
    .SW_LEVEL_OUT(lvl), .SW_OE_OUT(oe), .LED_RED_OUT(led),
    .DISP_MSG_OUT(msg), .DISP_ITEM_OUT(item), .DISP_VALUE_OUT(val),
    .DISP_EDIT_OUT(edit), .DISP_CURSOR_OUT(cur),
    .DISP_CURSOR_ON_OUT(con), .FILTER_OUT(filt), .UNITS_OUT(units),
    .LIVE_ZERO_OUT(lz), .SPAN_LO_OUT(slo), .SPAN_HI_OUT(shi));
  fls_ring_model fls_ring_model_inst (.clk_in(clk), .sw_level_in(lvl),
    .sw_oe_in(oe), .pos1_out(p1), .pos2_out(p2), .rx_level_out(rx));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  task chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  task wreg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task rreg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg
  task smp(input logic [15:0] v, input logic [1:0] e);
    @(posedge clk);
    flow <= v;
    fv <= 1'b1;
    @(posedge clk);
    fv <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk({14'h0, lvl}, {14'h0, e});
    chk({15'h0, led}, {15'h0, e != 2'b11});
    chk({14'h0, msg}, (e != 2'b11) ? 16'h0002 : 16'h0000);
  endtask : smp
  task ring(input logic two, input int n);
    repeat (n) fls_ring_model_inst.press(two);
    #1;
  endtask : ring
  task t_limits;
    wreg(4'h4, 16'h0001);
    wreg(4'h3, 16'h0070);
    smp(16'h0031, 2'b10);
    smp(16'h003c, 2'b10);
    smp(16'h003d, 2'b11);
    smp(16'h0047, 2'b01);
    smp(16'h0041, 2'b01);
    smp(16'h003b, 2'b11);
    $display("limits done");
  endtask : t_limits
  task t_overload;
    @(posedge clk);
    ovld <= 2'b01;
    repeat (6) @(posedge clk);
    #1 chk({14'h0, oe}, 16'h0002);
    chk({14'h0, msg}, 16'h0003);
    chk({14'h0, rx}, 16'h0002);
    @(posedge clk);
    ovld <= 2'b10;
    repeat (6) @(posedge clk);
    #1 chk({14'h0, oe}, 16'h0001);
    chk({14'h0, msg}, 16'h0003);
    chk({14'h0, rx}, 16'h0001);
    @(posedge clk);
    ovld <= 2'b00;
    repeat (6) @(posedge clk);
    #1 chk({14'h0, oe}, 16'h0003);
    chk({14'h0, msg}, 16'h0000);
    $display("overload done");
  endtask : t_overload
  task t_regs;
    wreg(4'h9, 16'h0001);
    wreg(4'h7, 16'h0005);
    wreg(4'ha, 16'h0020);
    wreg(4'hb, 16'h0300);
    wreg(4'h8, 16'h0003);
    wreg(4'he, 16'hffff);
    rreg(4'he);
    chk(d, 16'h0000);
    chk({15'h0, lz}, 16'h0001);
    chk(filt, 16'h0005);
    chk(units, 16'h0003);
    chk(slo, 16'h0020);
    chk(shi, 16'h0300);
    wreg(4'h9, 16'h0000);
    rreg(4'hb);
    chk(d, 16'h0300);
    chk({15'h0, lz}, 16'h0000);
    $display("registers done");
  endtask : t_regs
  task t_edit;
    ring(1'b0, 1);
    chk({12'h0, item}, 16'h0000);
    ring(1'b1, 1);
    chk({15'h0, edit}, 16'h0001);
    chk(val, 16'h0050);
    chk({15'h0, con}, 16'h0001);
    ring(1'b1, 1);
    chk(val, 16'h1050);
    ring(1'b0, 2);
    chk({14'h0, cur}, 16'h0002);
    ring(1'b1, 5);
    chk(val, 16'h1000);
    ring(1'b0, 2);
    chk({15'h0, edit}, 16'h0000);
    chk({15'h0, con}, 16'h0000);
    rreg(4'h0);
    chk(d, 16'h1000);
    $display("edit done");
  endtask : t_edit
  task t_code;
    ring(1'b0, 6);
    chk({12'h0, item}, 16'h0006);
    ring(1'b1, 1);
    ring(1'b0, 1);
    repeat (3) begin
      ring(1'b1, 1);
      ring(1'b0, 1);
    end
    ring(1'b0, 1);
    chk({12'h0, item}, 16'h0007);
    rreg(4'hc);
    chk(d, 16'h0710);
    ring(1'b0, 4);
    chk({12'h0, item}, 16'h000b);
    ring(1'b0, 8);
    chk({12'h0, item}, 16'h0006);
    ring(1'b0, 1);
    chk({14'h0, msg}, 16'h0000);
    $display("code done");
  endtask : t_code
  task t_timeout;
    ring(1'b0, 1);
    ring(1'b1, 2);
    chk(val, 16'h2000);
    // idle past eight ticks of four cycles plus latency
    repeat (60) @(posedge clk);
    #1 chk({15'h0, edit}, 16'h0000);
    chk({14'h0, msg}, 16'h0000);
    chk(val, 16'h003b);
    rreg(4'h0);
    chk(d, 16'h1000);
    $display("timeout done");
  endtask : t_timeout
  initial begin
    {rst_n, fv, wr, rd, ovld, addr, flow, wdata} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_limits();
    t_overload();
    t_regs();
    t_edit();
    t_code();
    t_timeout();
    summarize();
  end
endmodule : fls_top_tb_top
